/* File: rtl/pad_pkg.sv */
// Package for the peripheral auto powerdown block: offsets, field positions, reset values, timing.
// Assumes a single 40 MHz clock domain; every consumer imports the whole package.
package pad_pkg;
   // ----------------------------------------
   // Clock and timing.
   // ----------------------------------------
   localparam int CLK_MHZ = 40;                             // Device clock rate in MHz.
   localparam int PD_TIMER_MS = 10;                         // Floppy auto powerdown timer in ms.
   localparam int PD_TIMER_CYC = PD_TIMER_MS * 1000 * CLK_MHZ; // Cycles in the timer.
   // ----------------------------------------
   // Floppy register offsets.
   // ----------------------------------------
   localparam logic [2:0] OFS_STATUS_A = 3'h0;              // Status A, read.
   localparam logic [2:0] OFS_STATUS_B = 3'h1;              // Status B, read.
   localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;             // Drive output control, read/write.
   localparam logic [2:0] OFS_RATE_MAIN = 3'h4;             // Rate select write, main status read.
   localparam logic [2:0] OFS_FIFO_DATA = 3'h5;             // Data port, read/write.
   localparam logic [2:0] OFS_INSTAT_RATECFG = 3'h7;        // Input status read, rate config write.
   // ----------------------------------------
   // Field positions.
   // ----------------------------------------
   localparam int DRVOUT_RESET_N_BIT = 2;                   // Drive output control reset bit, low active.
   localparam int DRVOUT_MOTOR_LO = 4;                      // Lowest motor enable bit.
   localparam int RATESEL_SWRESET_BIT = 7;                  // Rate select software reset bit.
   localparam int APC_FDC_BIT = 0;                          // Auto power: floppy enable.
   localparam int APC_PAR_BIT = 3;                          // Auto power: parallel enable.
   localparam int APC_SER1_BIT = 4;                         // Auto power: serial 1 enable.
   localparam int APC_SER2_BIT = 5;                         // Auto power: serial 2 enable.
   localparam int PCC_FDC_BIT = 0;                          // Direct power: floppy on.
   localparam int PCC_PAR_BIT = 3;                          // Direct power: parallel on.
   localparam int PCC_SER1_BIT = 4;                         // Direct power: serial 1 on.
   localparam int PCC_SER2_BIT = 5;                         // Direct power: serial 2 on.
   // ----------------------------------------
   // Reset values.
   // ----------------------------------------
   localparam logic [7:0] DRVOUT_RESET_VAL = 8'h00;         // Drive output control after reset.
   localparam logic [7:0] RATESEL_RESET_VAL = 8'h02;        // Rate select after reset.
   localparam logic [7:0] XFERCFG_RESET_VAL = 8'h02;        // Rate config after reset.
   localparam logic [7:0] MAIN_STATUS_IDLE_VAL = 8'h80;     // Main status when idle.
   // ----------------------------------------
   // Extended control mode field values.
   // ----------------------------------------
   localparam logic [2:0] ECR_MODE_SPP = 3'h0;              // Standard mode.
   localparam logic [2:0] ECR_MODE_BIDIR = 3'h1;            // Bidirectional mode.
   localparam logic [2:0] ECR_MODE_EPP = 3'h4;              // EPP mode.
   // ----------------------------------------
   // Carrier types.
   // ----------------------------------------
   typedef struct packed {
      logic rd;                                             // Read strobe, one cycle.
      logic wr;                                             // Write strobe, one cycle.
      logic [2:0] addr;                                     // Register offset.
      logic [7:0] wdata;                                    // Write data.
   } pad_host_t;
   typedef struct packed {
      logic motorOn0N;                                      // Motor enable out.
      logic driveSelect0N;                                  // Drive select out.
      logic writeDataOutN;                                  // Write data out.
      logic writeGateN;                                     // Write gate out.
   } pad_fdd_gated_t;
endpackage

/* File: rtl/pad_sync2.sv */
// Two flip-flop synchroniser for a level from outside the clock domain.
// Assumes the clock enable only freezes the stages, never the reset.
`timescale 1ns/100ps
module pad_sync2
   import pad_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1; // First stage, read only by the second stage.
   // ----------------------------------------
   // Sync stages.
   // ----------------------------------------
   // The first stage feeds only dout so metastability never reaches decoding logic.
   // Both stages reset high, the idle level of every pin here, so no false edge follows reset.
   always_ff @(posedge mclk) begin
      if (reset) begin
         stage1 <= '1;
         dout <= '1;
      end else if (clkEn) begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // pad_sync2

/* File: rtl/pad_serial_pd.sv */
// Auto powerdown state of one serial port: transmitter and receiver halves.
// Assumes the receive input is already synchronised by the caller.
`timescale 1ns/100ps
module pad_serial_pd
   import pad_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic autoEn,
   input wire logic txEmpty,
   input wire logic txWrite,
   input wire logic rxFifoEmpty,
   input wire logic rxIdle,
   input wire logic rxSync,
   output logic txDown,
   output logic rxDown
);
   logic rxPrev; // Last synchronised receive level.
   // ----------------------------------------
   // Transmitter.
   // ----------------------------------------
   // A host write wakes the transmitter even in the cycle its buffers report empty.
   always_ff @(posedge mclk) begin
      if (reset) begin
         txDown <= 1'b0;
      end else if (clkEn) begin
         if (!autoEn || txWrite) begin
            txDown <= 1'b0;
         end else if (txEmpty) begin
            txDown <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // Receiver.
   // ----------------------------------------
   // Only the synchronised level is compared, so a glitch cannot split the state.
   always_ff @(posedge mclk) begin
      if (reset) begin
         rxPrev <= 1'b1;
         rxDown <= 1'b0;
      end else if (clkEn) begin
         rxPrev <= rxSync;
         if (!autoEn || rxSync != rxPrev) begin
            rxDown <= 1'b0;
         end else if (rxFifoEmpty && rxIdle) begin
            rxDown <= 1'b1;
         end
      end
   end
   chk_tx_wake: assert property (@(posedge mclk) disable iff (reset)
      clkEn && txWrite |=> !txDown) else $error("Transmitter did not wake on write.");
   chk_rx_entry: assert property (@(posedge mclk) disable iff (reset)
      $rose(rxDown) |-> $past(rxFifoEmpty) && $past(rxIdle)) else $error("Receiver slept while busy.");
endmodule // pad_serial_pd

/* File: rtl/pad_power_ctrl.sv */
// Peripheral auto powerdown controller: host gating, PLL control, floppy wake logic, serial and parallel.
// Assumes host strobes are one-cycle pulses on mclk; wake pins come from outside the domain.
`timescale 1ns/100ps
module pad_power_ctrl
   import pad_pkg::*;
#(
   parameter int PD_CYCLES = PD_TIMER_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic internalPowerOk,
   input wire logic standbySupply,
   input wire pad_host_t hostIn,
   output logic [7:0] hostRdata,
   input wire logic [7:0] powerControlConfig,
   input wire logic [7:0] autoPowerConfig,
   input wire logic pllControlBit,
   input wire logic pmePowerBit,
   output logic pllPowered,
   output logic pllSelected,
   input wire logic fdcIrqIn,
   input wire logic fdcDrqIn,
   output logic fdcIrqOut,
   output logic fdcDrqOut,
   input wire logic [7:0] fdcStatusA,
   input wire logic [7:0] fdcStatusB,
   input wire logic [7:0] driveInputStatus,
   input wire logic [7:0] fdcMainStatus,
   input wire logic [7:0] fifoReadData,
   input wire logic headUnloadDone,
   input wire logic fdcIntPending,
   output logic fdcDataRead,
   output logic fdcDataWrite,
   output logic [7:0] driveOutputControl,
   output logic [7:0] rateSelectControl,
   output logic [7:0] transferRateConfig,
   output logic fdcPoweredDown,
   input wire pad_fdd_gated_t fddCoreOut,
   output pad_fdd_gated_t fddPinOut,
   output pad_fdd_gated_t fddPinOe,
   input wire logic keyboardClockIn,
   input wire logic mouseClockIn,
   input wire logic infraredReceiveIn,
   input wire logic ringIndicate1N,
   input wire logic ringIndicate2N,
   input wire logic serial1ReceiveIn,
   input wire logic serial2ReceiveIn,
   input wire logic wakeEventReq,
   output logic wakeEventOutN,
   output logic [4:0] wakePinLevel,
   output logic [1:0] ringChange,
   input wire logic [1:0] txEmpty,
   input wire logic [1:0] txHoldWrite,
   input wire logic [1:0] rxFifoEmpty,
   input wire logic [1:0] rxIdle,
   output logic [1:0] serialTxDown,
   output logic [1:0] serialRxDown,
   input wire logic eppEnabled,
   input wire logic ecpEnabled,
   input wire logic [2:0] ecrMode,
   output logic eppDown,
   output logic ecpDown,
   output logic parModeChanged
);
   // ----------------------------------------
   // Synchronised pins.
   // ----------------------------------------
   logic [6:0] pinRaw; // Asynchronous wake and receive pins.
   logic [6:0] pinSync; // Their synchronised copies.
   logic [1:0] ringPrev; // Last ring levels for change detection.
   logic hostRd; // Read accepted by decode.
   logic hostWr; // Write accepted by decode.
   logic wakeAccess; // Access that leaves powerdown.
   logic fdcAutoDown; // Auto powerdown state.
   logic [$clog2(PD_CYCLES+1)-1:0] pdTimer; // Powerdown timer count.
   logic timerDone; // Timer has elapsed.
   logic fdcEntryOk; // All entry conditions met.
   logic [2:0] ecrPrev; // Last extended control mode.
   logic [1:0] cfgPrev; // Last configured port modes.
   logic [1:0] serialAuto; // Per-port auto enables.
   assign pinRaw = {serial2ReceiveIn, serial1ReceiveIn, ringIndicate2N, ringIndicate1N,
                    infraredReceiveIn, mouseClockIn, keyboardClockIn};
   // Every pin level passes both stages before any edge or level logic reads it.
   pad_sync2 #(.W(7)) uSync (
      .mclk(mclk),
      .reset(reset),
      .clkEn(clkEn),
      .din(pinRaw),
      .dout(pinSync)
   );
   // ----------------------------------------
   // Standby wake interface.
   // ----------------------------------------
   // These paths are not gated by power good, only by the standby supply.
   always_ff @(posedge mclk) begin
      if (reset) begin
         wakeEventOutN <= 1'b1;
         wakePinLevel <= '0;
         ringPrev <= 2'b11;
         ringChange <= '0;
      end else if (clkEn) begin
         wakeEventOutN <= !(standbySupply && wakeEventReq);
         wakePinLevel <= standbySupply ? pinSync[4:0] : 5'h00;
         ringPrev <= pinSync[4:3];
         ringChange <= standbySupply ? (pinSync[4:3] ^ ringPrev) : 2'b00;
      end
   end
   // ----------------------------------------
   // Host decode gating.
   // ----------------------------------------
   // Gating at the strobes keeps every host register and access wake path blind while power is not good.
   assign hostRd = hostIn.rd && internalPowerOk;
   assign hostWr = hostIn.wr && internalPowerOk;
   // ----------------------------------------
   // PLL control.
   // ----------------------------------------
   // Reserved combinations leave the PLL powered but not selected, the safe choice.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pllPowered <= 1'b0;
         pllSelected <= 1'b0;
      end else if (clkEn) begin
         pllPowered <= !pllControlBit;
         pllSelected <= !pllControlBit && !pmePowerBit && internalPowerOk;
      end
   end
   // ----------------------------------------
   // Floppy registers kept during powerdown.
   // ----------------------------------------
   // Writes are stored whatever the floppy powerdown state, so they show after wake.
   always_ff @(posedge mclk) begin
      if (reset) begin
         driveOutputControl <= DRVOUT_RESET_VAL;
         rateSelectControl <= RATESEL_RESET_VAL;
         transferRateConfig <= XFERCFG_RESET_VAL;
      end else if (clkEn && hostWr) begin
         case (hostIn.addr)
            OFS_DRIVE_OUT: driveOutputControl <= hostIn.wdata;
            OFS_RATE_MAIN: rateSelectControl <= hostIn.wdata;
            OFS_INSTAT_RATECFG: transferRateConfig <= hostIn.wdata;
            default: ;
         endcase
      end
   end
   // Reads of status A, status B and input status return the live status inputs; drive output control reads back its register.
   always_ff @(posedge mclk) begin
      if (reset) begin
         hostRdata <= 8'h00;
      end else if (clkEn && hostRd) begin
         case (hostIn.addr)
            OFS_STATUS_A: hostRdata <= fdcStatusA;
            OFS_STATUS_B: hostRdata <= fdcStatusB;
            OFS_DRIVE_OUT: hostRdata <= driveOutputControl;
            OFS_RATE_MAIN: hostRdata <= fdcMainStatus;
            OFS_FIFO_DATA: hostRdata <= fifoReadData;
            OFS_INSTAT_RATECFG: hostRdata <= driveInputStatus;
            default: hostRdata <= 8'h00;
         endcase
      end
   end
   assign fdcDataRead = hostRd && hostIn.addr == OFS_FIFO_DATA;
   assign fdcDataWrite = hostWr && hostIn.addr == OFS_FIFO_DATA;
   // ----------------------------------------
   // Wake decode.
   // ----------------------------------------
   // A main status read, any data port access, or a write that starts a motor or pulls a reset bit wakes; other register traffic does not.
   always_comb begin
      wakeAccess = 1'b0;
      if (hostRd && hostIn.addr == OFS_RATE_MAIN) begin
         wakeAccess = 1'b1;
      end
      if ((hostRd || hostWr) && hostIn.addr == OFS_FIFO_DATA) begin
         wakeAccess = 1'b1;
      end
      if (hostWr && hostIn.addr == OFS_DRIVE_OUT &&
          (|hostIn.wdata[7:DRVOUT_MOTOR_LO] || !hostIn.wdata[DRVOUT_RESET_N_BIT])) begin
         wakeAccess = 1'b1;
      end
      if (hostWr && hostIn.addr == OFS_RATE_MAIN && hostIn.wdata[RATESEL_SWRESET_BIT]) begin
         wakeAccess = 1'b1;
      end
   end
   // ----------------------------------------
   // Floppy auto powerdown.
   // ----------------------------------------
   assign timerDone = pdTimer == '0;
   // A pending interrupt blocks entry even with an idle main status, since polling may leave one set.
   assign fdcEntryOk = autoPowerConfig[APC_FDC_BIT] && ~|driveOutputControl[7:DRVOUT_MOTOR_LO] &&
                       fdcMainStatus == MAIN_STATUS_IDLE_VAL && !fdcIntPending && headUnloadDone && timerDone;
   // Timer restarts on every wake and on disable; it counts down only while enabled.
   always_ff @(posedge mclk) begin
      if (reset) begin
         pdTimer <= ($clog2(PD_CYCLES+1))'(PD_CYCLES);
      end else if (clkEn) begin
         if (!autoPowerConfig[APC_FDC_BIT] || wakeAccess) begin
            pdTimer <= ($clog2(PD_CYCLES+1))'(PD_CYCLES);
         end else if (!timerDone) begin
            pdTimer <= pdTimer - 1'b1;
         end
      end
   end
   // Non-waking accesses never touch this state, so the part stays in low power.
   always_ff @(posedge mclk) begin
      if (reset) begin
         fdcAutoDown <= 1'b0;
      end else if (clkEn) begin
         if (wakeAccess || !autoPowerConfig[APC_FDC_BIT]) begin
            fdcAutoDown <= 1'b0;
         end else if (fdcEntryOk) begin
            fdcAutoDown <= 1'b1;
         end
      end
   end
   assign fdcPoweredDown = fdcAutoDown || !powerControlConfig[PCC_FDC_BIT];
   // ----------------------------------------
   // Floppy pins and host outputs.
   // ----------------------------------------
   // Only motor, select and write lines float; step, head and density pass untouched.
   always_ff @(posedge mclk) begin
      if (reset) begin
         fddPinOut <= '1;
         fddPinOe <= '0;
         fdcIrqOut <= 1'b0;
         fdcDrqOut <= 1'b0;
      end else if (clkEn) begin
         fddPinOut <= fddCoreOut;
         fddPinOe <= fdcPoweredDown ? '0 : '1;
         fdcIrqOut <= fdcPoweredDown ? 1'b0 : fdcIrqIn;
         fdcDrqOut <= fdcPoweredDown ? 1'b0 : fdcDrqIn;
      end
   end
   // ----------------------------------------
   // Serial ports.
   // ----------------------------------------
   // The auto enable only permits sleep; direct powerdown still overrides it per port.
   assign serialAuto = {autoPowerConfig[APC_SER2_BIT], autoPowerConfig[APC_SER1_BIT]};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : gSerial
         logic txAuto; // Transmitter auto state.
         logic rxAuto; // Receiver auto state.
         pad_serial_pd uSer (
            .mclk(mclk),
            .reset(reset),
            .clkEn(clkEn),
            .autoEn(serialAuto[gi]),
            .txEmpty(txEmpty[gi]),
            .txWrite(txHoldWrite[gi] && internalPowerOk),
            .rxFifoEmpty(rxFifoEmpty[gi]),
            .rxIdle(rxIdle[gi]),
            .rxSync(pinSync[5+gi]),
            .txDown(txAuto),
            .rxDown(rxAuto)
         );
         assign serialTxDown[gi] = txAuto || !powerControlConfig[PCC_SER1_BIT+gi];
         assign serialRxDown[gi] = rxAuto || !powerControlConfig[PCC_SER1_BIT+gi];
      end
   endgenerate
   // ----------------------------------------
   // Parallel port.
   // ----------------------------------------
   // Recomputed on every enabled cycle, so any mode change shows at the next enabled edge.
   always_ff @(posedge mclk) begin
      if (reset) begin
         eppDown <= 1'b0;
         ecpDown <= 1'b0;
         ecrPrev <= ECR_MODE_SPP;
         cfgPrev <= 2'b00;
         parModeChanged <= 1'b0;
      end else if (clkEn) begin
         // Direct powerdown is ORed in ahead of auto, so no mode can mask it.
         ecrPrev <= ecrMode;
         cfgPrev <= {ecpEnabled, eppEnabled};
         parModeChanged <= ecrMode != ecrPrev || {ecpEnabled, eppEnabled} != cfgPrev;
         eppDown <= !powerControlConfig[PCC_PAR_BIT] || (autoPowerConfig[APC_PAR_BIT] &&
                    (!eppEnabled || (ecpEnabled && ecrMode != ECR_MODE_EPP)));
         ecpDown <= !powerControlConfig[PCC_PAR_BIT] || (autoPowerConfig[APC_PAR_BIT] &&
                    (!ecpEnabled || ecrMode == ECR_MODE_SPP || ecrMode == ECR_MODE_BIDIR ||
                     ecrMode == ECR_MODE_EPP));
      end
   end
   // ----------------------------------------
   // Checks.
   // ----------------------------------------
   chk_pwr_decode: assert property (@(posedge mclk) disable iff (reset)
      !internalPowerOk |-> !fdcDataRead && !fdcDataWrite) else $error("Decode while power not good.");
   chk_pll_down: assert property (@(posedge mclk) disable iff (reset)
      clkEn && pllControlBit |=> !pllPowered && !pllSelected) else $error("PLL not powered down.");
   chk_msr_wake: assert property (@(posedge mclk) disable iff (reset)
      clkEn && hostRd && hostIn.addr == OFS_RATE_MAIN |=> !fdcAutoDown) else $error("Status read did not wake.");
   chk_dor_stay: assert property (@(posedge mclk) disable iff (reset)
      clkEn && fdcAutoDown && !wakeAccess && autoPowerConfig[APC_FDC_BIT] |=> fdcAutoDown)
      else $error("Non-waking access woke floppy.");
   chk_entry_cond: assert property (@(posedge mclk) disable iff (reset)
      $rose(fdcAutoDown) |-> $past(timerDone) && $past(headUnloadDone)) else $error("Early floppy powerdown.");
   chk_timer_restart: assert property (@(posedge mclk) disable iff (reset)
      clkEn && wakeAccess |=> !timerDone ##1 !fdcAutoDown) else $error("Timer not restarted.");
   chk_pin_float: assert property (@(posedge mclk) disable iff (reset)
      clkEn && fdcPoweredDown |=> fddPinOe == '0) else $error("Floppy pins driven in powerdown.");
   chk_irq_low: assert property (@(posedge mclk) disable iff (reset)
      clkEn && fdcPoweredDown |=> !fdcIrqOut && !fdcDrqOut) else $error("Request active in powerdown.");
   chk_ecp_mode: assert property (@(posedge mclk) disable iff (reset)
      clkEn && autoPowerConfig[APC_PAR_BIT] && ecrMode == ECR_MODE_EPP |=> ecpDown) else $error("ECP not down.");
   // Ring changes must still reach the serial interrupt logic while the ports sleep.
   chk_ring_live: assert property (@(posedge mclk) disable iff (reset)
      clkEn && standbySupply && pinSync[4:3] != ringPrev |=> |ringChange) else $error("Ring change lost.");
   chk_par_change: assert property (@(posedge mclk) disable iff (reset)
      clkEn && ecrMode != ecrPrev |=> parModeChanged) else $error("Mode change not flagged.");
   chk_ser_gate: assert property (@(posedge mclk) disable iff (reset)
      clkEn && !autoPowerConfig[APC_SER1_BIT] |=> serialTxDown[0] == !powerControlConfig[PCC_SER1_BIT])
      else $error("Serial slept without auto enable.");
   // Covers for the main sleep and wake scenarios.
   cov_fdc_sleep: cover property (@(posedge mclk) $rose(fdcAutoDown));
   cov_fdc_wake: cover property (@(posedge mclk) fdcAutoDown ##1 !fdcAutoDown);
   cov_ser_sleep: cover property (@(posedge mclk) $rose(serialRxDown[0]));
   cov_epp_down: cover property (@(posedge mclk) $rose(eppDown));
endmodule // pad_power_ctrl

/* File: verification/pad_fdc_model.sv */
// Behavioural floppy core behind the powerdown controller.
// Assumes one clock; it sits idle so that auto powerdown may be entered.
`timescale 1ns/100ps
module pad_fdc_model
   import pad_pkg::*;
(
   input wire logic mclk,
   input wire logic fdcDataRead,
   output logic [7:0] fdcStatusA,
   output logic [7:0] fdcStatusB,
   output logic [7:0] driveInputStatus,
   output logic [7:0] fdcMainStatus,
   output logic [7:0] fifoReadData,
   output logic headUnloadDone,
   output logic fdcIntPending,
   output pad_fdd_gated_t fddCoreOut
);
   // Idle core: ready, no interrupt, heads unloaded, drive lines inactive.
   assign fdcMainStatus = MAIN_STATUS_IDLE_VAL;
   assign fdcIntPending = 1'b0;
   assign headUnloadDone = 1'b1;
   assign fdcStatusA = 8'hA5;
   assign fdcStatusB = 8'h5A;
   assign driveInputStatus = 8'h80;
   assign fddCoreOut = '1;
   // Each data read moves the byte on, so a stale read shows up.
   initial fifoReadData = 8'h3C;
   always @(posedge mclk) begin
      if (fdcDataRead) begin
         fifoReadData <= fifoReadData + 8'h01;
      end
   end
endmodule // pad_fdc_model

/* File: verification/peripheral_auto_powerdown_tb_top.sv */
// Self-checking bench: PLL, host gating, floppy wake, serial and parallel powerdown.
// Assumes the floppy model beside the design and a 40 MHz clock.
`timescale 1ns/100ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin numErrors++; $display("ERROR %0t mismatch", $time); end end
module peripheral_auto_powerdown_tb_top;
   import pad_pkg::*;
   localparam int PDC = 20; // Short powerdown timer so the run stays brief.
   logic mclk = 0, reset = 1, clkEn = 1, internalPowerOk = 1, standbySupply = 1, pllControlBit = 0, pmePowerBit = 0;
   logic fdcIrqIn = 0, fdcDrqIn = 0, keyboardClockIn = 1, mouseClockIn = 1, infraredReceiveIn = 1, ringIndicate1N = 1;
   logic ringIndicate2N = 1, serial1ReceiveIn = 1, serial2ReceiveIn = 1, wakeEventReq = 0, eppEnabled = 0, ecpEnabled = 0;
   logic [1:0] txEmpty = 0, txHoldWrite = 0, rxFifoEmpty = 0, rxIdle = 0, ringChange, serialTxDown, serialRxDown;
   logic [7:0] powerControlConfig = 8'hFF, autoPowerConfig = 8'h00, hostRdata, driveOutputControl;
   logic [7:0] rateSelectControl, transferRateConfig, fdcStatusA, fdcStatusB, driveInputStatus, fdcMainStatus, fifoReadData;
   logic [2:0] ecrMode = 0;
   logic [4:0] wakePinLevel;
   logic pllPowered, pllSelected, fdcIrqOut, fdcDrqOut, fdcDataRead, fdcDataWrite, fdcPoweredDown, wakeEventOutN;
   logic eppDown, ecpDown, parModeChanged, headUnloadDone, fdcIntPending, pend = 0, woke;
   pad_host_t hostIn = '0;
   pad_fdd_gated_t fddCoreOut, fddPinOut, fddPinOe;
   logic [7:0] expQ[$]; // Expected read data, oldest first.
   logic [2:0] modes[4] = '{ECR_MODE_SPP, ECR_MODE_BIDIR, ECR_MODE_EPP, 3'h3};
   int numErrors = 0, nCompared = 0;
   pad_power_ctrl #(.PD_CYCLES(PDC)) pad_power_ctrl_inst (.*);
   pad_fdc_model pad_fdc_model_inst (.*);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One host cycle; a read notes its expected data for the monitor.
   task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
      hostIn = '{rd: r, wr: !r, addr: a, wdata: d};
      if (r && internalPowerOk) expQ.push_back(a == OFS_STATUS_A ? fdcStatusA : a == OFS_RATE_MAIN ? fdcMainStatus : fifoReadData);
      cyc(1);
      hostIn = '0;
      cyc(1);
   endtask
   // Read data lands one cycle after the taking edge.
   always @(posedge mclk) begin
      if (pend) `CHK(hostRdata, expQ.pop_front())
      pend <= hostIn.rd && internalPowerOk;
   end
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial begin
      void'($urandom(32'h244b));
      cyc(12);
      reset = 0;
      `CHK({rateSelectControl, transferRateConfig}, {RATESEL_RESET_VAL, XFERCFG_RESET_VAL})
      for (int i = 0; i < 8; i++) begin
         {pllControlBit, pmePowerBit, internalPowerOk} = 3'(i);
         cyc(2);
         `CHK(pllPowered, !pllControlBit)
         `CHK(pllSelected, i == 1)
      end
      {pllControlBit, pmePowerBit} = 2'b00;
      {keyboardClockIn, mouseClockIn, infraredReceiveIn, ringIndicate1N, ringIndicate2N, wakeEventReq, fdcIrqIn} = 7'($urandom);
      internalPowerOk = 0;
      cyc(5);
      `CHK(wakePinLevel, {ringIndicate2N, ringIndicate1N, infraredReceiveIn, mouseClockIn, keyboardClockIn})
      `CHK(wakeEventOutN, !wakeEventReq)
      acc(0, OFS_DRIVE_OUT, 8'hF0);
      `CHK(driveOutputControl, DRVOUT_RESET_VAL)
      internalPowerOk = 1;
      $display("test pll and gating done");
      autoPowerConfig = 8'h39;
      {txEmpty, rxFifoEmpty, rxIdle} = '1;
      cyc(PDC + 8);
      `CHK({fdcPoweredDown, fddPinOe, fdcIrqOut}, 6'b100000)
      `CHK({serialTxDown, serialRxDown}, 4'hF)
      acc(1, OFS_STATUS_A, 8'h00);
      acc(0, OFS_DRIVE_OUT, 8'h0C);
      `CHK({fdcPoweredDown, driveOutputControl}, 9'h10C)
      acc(1, OFS_RATE_MAIN, 8'h00);
      `CHK(fdcPoweredDown, 1'b0)
      cyc(PDC - 6);
      `CHK(fdcPoweredDown, 1'b0)
      cyc(10);
      `CHK(fdcPoweredDown, 1'b1)
      acc(0, OFS_DRIVE_OUT, 8'h1C);
      `CHK({fdcPoweredDown, fddPinOe}, 5'h0F)
      acc(0, OFS_DRIVE_OUT, 8'h0C);
      $display("test floppy done");
      ringIndicate1N = !ringIndicate1N;
      cyc(3);
      `CHK(ringChange, 2'b01)
      {txHoldWrite, txEmpty} = 4'b0110;
      cyc(1);
      txHoldWrite = 2'b00;
      `CHK(serialTxDown[0], 1'b0)
      serial1ReceiveIn = 0;
      woke = 0;
      repeat (6) begin
         cyc(1);
         woke |= !serialRxDown[0];
      end
      `CHK(woke, 1'b1)
      {eppEnabled, ecpEnabled} = 2'b11;
      foreach (modes[i]) begin
         ecrMode = modes[i];
         cyc(1);
         `CHK(parModeChanged, 1'b1)
         cyc(1);
         `CHK(eppDown, modes[i] != ECR_MODE_EPP)
         `CHK(ecpDown, modes[i] != 3'h3)
      end
      {clkEn, ecpEnabled} = 2'b00;
      cyc(2);
      `CHK(ecpDown, 1'b0)
      clkEn = 1;
      cyc(2);
      `CHK(ecpDown, 1'b1)
      autoPowerConfig = 8'h00;
      cyc(2);
      `CHK({eppDown, serialTxDown}, 3'b000)
      powerControlConfig = 8'h00;
      cyc(2);
      `CHK({fdcPoweredDown, serialTxDown}, 3'b111)
      $display("test serial and parallel done");
      tally_and_finish();
   end
   // Watchdog: the tests take well under this span.
   initial begin
      #100us;
      numErrors++;
      tally_and_finish();
   end
endmodule // peripheral_auto_powerdown_tb_top
